// ### src/psr_consts.svh
// Constants shared by both ends of the pressure readout link.
// Definitions only; included by bare name from the design files.
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// Core clock rate and period
`define PSR_CLK_MHZ 200
`define PSR_CLK_NS 5
// Start-up: first command after 1 ms, first measurement after 2.5 ms
`define PSR_T_CMD_US 1000
`define PSR_T_MEAS_US 2500
// Conversion time of one measurement, in core cycles
`define PSR_CONV_CYC 1000
// Half period of the serial clock made by the master: 400 kHz, the two-wire ceiling
`define PSR_T_HALF_NS 1250

// Target address: upper three bits selectable, low nibble fixed
`define PSR_ADDR_LO 4'h8
`define PSR_ADDR_SEL 3'h1

// Command bytes
`define PSR_CMD_MEAS 8'hAA
`define PSR_CMD_ARG 8'h00
`define PSR_CMD_NOP 8'hF0

// Status byte bit positions
`define PSR_ST_POWER 6
`define PSR_ST_BUSY 5
`define PSR_ST_MEMERR 2
`define PSR_ST_SAT 0

`endif

// ### src/psr_pkg.sv
// Types shared by both ends of the pressure readout link.
// Assumes nothing of its surroundings.
package psr_pkg;

    // Two-wire target states, Gray along address, ack, read, read ack
    typedef enum logic [2:0] {
        i_idle = 3'b000,
        i_addr = 3'b001,
        i_aack = 3'b011,
        i_rd = 3'b010,
        i_rack = 3'b110,
        i_wr = 3'b111,
        i_wack = 3'b101
    } psr_i2c_st_t;

    // Master sequencer states
    typedef enum logic [2:0] {
        h_idle = 3'b000,
        h_start = 3'b001,
        h_blo = 3'b011,
        h_bhi = 3'b010,
        h_stop = 3'b110,
        h_stop2 = 3'b111,
        h_done = 3'b101
    } psr_host_st_t;

endpackage

// ### src/psr_link_if.sv
// Wires between the master and the sensor: two-wire bus and four-wire bus.
// The bench joins both ends here; open-drain lines resolve as pulled up.
`timescale 1ns/1ps
interface psr_link_if;
    // Two-wire bus, open drain
    logic scl_h_o;
    logic scl_h_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // Four-wire bus
    logic sclk;
    logic mosi;
    logic ss_n;
    logic miso_d;
    logic miso_oe;
    logic miso;

    assign scl = ~(scl_h_oe & ~scl_h_o);
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
    // Undriven data line reads low, as an unpowered sensor would
    assign miso = miso_oe & miso_d;

    modport host (
        output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, sclk, mosi, ss_n,
        input sda, miso
    );
    modport dev (
        output sda_d_o, sda_d_oe, miso_d, miso_oe,
        input scl, sda, sclk, mosi, ss_n
    );
endinterface

// ### src/psr_sensor.sv
// Sensor end: two-wire target, four-wire target and the measurement core.
// Assumes a core clock, a master that obeys the bus rules, and a front end
// that presents a pressure word and a saturation flag.
//
// What this block does
// - Never starts bus traffic, only answers
// - Read returns status then 24-bit pressure
// - Matches a 7-bit address, default 0x18
// - Address build option: 0x08 to 0x78
// - Master sends START, address, read bit
// - Master acks bytes, ends with NACK, STOP
// - Status bit 6 one; bits 7,4,3,1 zero
// - Bit 5 busy; commands ignored while busy
// - Bit 2 memory check, fixed at power-up
// - Bit 0 flags arithmetic saturation
// - AA 00 00 starts a measurement
// - Returns to standby after the measurement
// - Master drives clock, MOSI, select; sensor MISO
// - MISO inactive, bus ignored unless selected
// - Selected sensor shifts out on clocks
// - Mode 0: sample rising, change falling
// - Four-wire read: status then pressure
// - Master ends at byte boundary, then deselects
// - Command after 1 ms, measurement after 2.5 ms
// - Byte F0 reads without a new command
`timescale 1ns/1ps
`include "psr_consts.svh"
module psr_sensor import psr_pkg::*; #(
    parameter int unsigned CMD_CYC = `PSR_T_CMD_US * `PSR_CLK_MHZ,
    parameter int unsigned MEAS_CYC = `PSR_T_MEAS_US * `PSR_CLK_MHZ,
    parameter logic [2:0] ADDR_SEL = `PSR_ADDR_SEL
) (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sensing front end
    input wire logic [23:0] press_i,
    input wire logic sat_i,
    input wire logic mem_fault_i,
    // Core state
    output logic busy_o,
    // Link
    psr_link_if.dev link
);

    localparam logic [15:0] CONV_LAST = 16'(`PSR_CONV_CYC - 1);
    localparam logic [6:0] MY_ADDR = {ADDR_SEL, `PSR_ADDR_LO};

    logic [31:0] pwr_cnt;
    logic cmd_ok;
    logic meas_ok;
    logic busy;
    logic mem_err;
    logic sat;
    logic [23:0] press;
    logic [15:0] conv_cnt;
    logic conv_end;
    logic cmd;
    logic cmd_i2c;
    logic cmd_spi;
    logic [7:0] status;
    logic [31:0] word;
    logic [31:0] sword;

    ////////////////////////////////////////////////////////////////////////
    // Power-up sequence and memory check

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_cnt <= 32'h0;
        end else if (!meas_ok) begin
            pwr_cnt <= pwr_cnt + 32'h1;
        end
    end

    assign cmd_ok = pwr_cnt >= CMD_CYC;
    assign meas_ok = pwr_cnt >= MEAS_CYC;

    // Checked once while powering up, then frozen until the next reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_err <= 1'b0;
        end else if (pwr_cnt == CMD_CYC - 1) begin
            mem_err <= mem_fault_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement cycle

    assign cmd = cmd_i2c | cmd_spi;
    assign conv_end = busy && meas_ok && conv_cnt == CONV_LAST;

    // A command taken early waits until the measurement may begin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            conv_cnt <= 16'h0;
        end else if (!busy) begin
            if (cmd && cmd_ok) begin
                busy <= 1'b1;
                conv_cnt <= 16'h0;
            end
        end else if (conv_end) begin
            busy <= 1'b0;
        end else if (meas_ok) begin
            conv_cnt <= conv_cnt + 16'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            press <= 24'h0;
            sat <= 1'b0;
        end else if (conv_end) begin
            press <= press_i;
            sat <= sat_i;
        end
    end

    always_comb begin
        status = 8'h00;
        status[`PSR_ST_POWER] = 1'b1;
        status[`PSR_ST_BUSY] = busy;
        status[`PSR_ST_MEMERR] = mem_err;
        status[`PSR_ST_SAT] = sat;
    end

    assign word = {status, press};
    assign busy_o = busy;

    ////////////////////////////////////////////////////////////////////////
    // Two-wire target, sampled on the core clock

    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    psr_i2c_st_t ist;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [31:0] tx;
    logic drv;
    logic nack;
    logic [1:0] widx;
    logic wok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= link.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= link.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop = scl_s & scl_d & ~sda_d & sda_s;
    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;

    // The line is only ever pulled low after our own address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist <= i_idle;
            bitc <= 4'h0;
            sh <= 8'h00;
            tx <= 32'h0;
            drv <= 1'b0;
            nack <= 1'b0;
            widx <= 2'h0;
            wok <= 1'b0;
            cmd_i2c <= 1'b0;
        end else begin
            cmd_i2c <= 1'b0;
            if (start) begin
                ist <= i_addr;
                bitc <= 4'h0;
                drv <= 1'b0;
            end else if (stop) begin
                ist <= i_idle;
                drv <= 1'b0;
            end else if (rise) begin
                if (ist == i_addr || ist == i_wr) begin
                    sh <= {sh[6:0], sda_s};
                    bitc <= bitc + 4'h1;
                end
                if (ist == i_rack) begin
                    nack <= sda_s;
                end
            end else if (fall) begin
                unique case (ist)
                    i_addr: if (bitc == 4'h8) begin
                        if (sh[7:1] == MY_ADDR) begin
                            ist <= i_aack;
                            drv <= 1'b1;
                        end else begin
                            ist <= i_idle;
                        end
                    end
                    i_aack: begin
                        bitc <= 4'h0;
                        widx <= 2'h0;
                        if (sh[0]) begin
                            ist <= i_rd;
                            tx <= word;
                            drv <= ~word[31];
                        end else begin
                            ist <= i_wr;
                            drv <= 1'b0;
                        end
                    end
                    i_rd: if (bitc == 4'h7) begin
                        ist <= i_rack;
                        drv <= 1'b0;
                        bitc <= 4'h0;
                    end else begin
                        tx <= {tx[30:0], 1'b1};
                        drv <= ~tx[30];
                        bitc <= bitc + 4'h1;
                    end
                    i_rack: if (nack) begin
                        ist <= i_idle;
                        drv <= 1'b0;
                    end else begin
                        ist <= i_rd;
                        tx <= {tx[30:0], 1'b1};
                        drv <= ~tx[30];
                    end
                    i_wr: if (bitc == 4'h8) begin
                        ist <= i_wack;
                        drv <= 1'b1;
                        if (widx != 2'h3) begin
                            widx <= widx + 2'h1;
                        end
                        if (widx == 2'h0) begin
                            wok <= sh == `PSR_CMD_MEAS;
                        end else begin
                            wok <= wok & (sh == `PSR_CMD_ARG);
                        end
                        if (widx == 2'h2 && wok && sh == `PSR_CMD_ARG) begin
                            cmd_i2c <= 1'b1;
                        end
                    end
                    i_wack: begin
                        ist <= i_wr;
                        drv <= 1'b0;
                        bitc <= 4'h0;
                    end
                    default: begin
                        drv <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = drv;

    ////////////////////////////////////////////////////////////////////////
    // Four-wire target, clocked by the master's serial clock

    logic ss_m;
    logic ss_s;
    logic [5:0] sbit;
    logic [22:0] rxs;
    logic scmd;
    logic miso;
    logic scm;
    logic scs;
    logic scd;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ss_m <= 1'b1;
            ss_s <= 1'b1;
        end else begin
            ss_m <= link.ss_n;
            ss_s <= ss_m;
        end
    end

    // Frozen while selected; the select-to-clock gap dwarfs the sync delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sword <= 32'h0;
        end else if (ss_s) begin
            sword <= word;
        end
    end

    // Deselect clears the frame, since the clock may stand still between
    always_ff @(posedge link.sclk or posedge link.ss_n) begin
        if (link.ss_n) begin
            sbit <= 6'h0;
            rxs <= 23'h0;
            scmd <= 1'b0;
        end else begin
            rxs <= {rxs[21:0], link.mosi};
            if (sbit != 6'h20) begin
                sbit <= sbit + 6'h1;
            end
            if (sbit == 6'h17 && {rxs, link.mosi} == {`PSR_CMD_MEAS, `PSR_CMD_ARG, `PSR_CMD_ARG}) begin
                scmd <= 1'b1;
            end
        end
    end

    // First bit is status bit 7, always zero, so the cleared value serves
    always_ff @(negedge link.sclk or posedge link.ss_n) begin
        if (link.ss_n) begin
            miso <= 1'b0;
        end else begin
            miso <= sbit[5] ? 1'b0 : sword[~sbit[4:0]];
        end
    end

    assign link.miso_d = miso;
    assign link.miso_oe = ~link.ss_n;

    // Command flag holds until deselect, so a level sync is enough
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scm <= 1'b0;
            scs <= 1'b0;
            scd <= 1'b0;
        end else begin
            scm <= scmd;
            scs <= scm;
            scd <= scs;
        end
    end

    assign cmd_spi = scs & ~scd;

endmodule // psr_sensor

// ### src/psr_master.sv
// Master end: issues measurement commands and reads results over either bus.
// Assumes one core clock; both serial clocks are divided down from it.
`timescale 1ns/1ps
`include "psr_consts.svh"
module psr_master import psr_pkg::*; #(
    parameter int unsigned BOOT_CYC = `PSR_T_CMD_US * `PSR_CLK_MHZ,
    parameter logic [2:0] ADDR_SEL = `PSR_ADDR_SEL
) (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request
    input wire logic req_i,
    input wire logic spi_i,
    input wire logic read_i,
    // Answer
    output logic ready_o,
    output logic busy_o,
    output logic done_o,
    output logic ack_err_o,
    output logic [7:0] status_o,
    output logic [23:0] press_o,
    // Link
    psr_link_if.host link
);

    localparam logic [9:0] HALF = 10'((`PSR_T_HALF_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS);
    localparam logic [9:0] MID = HALF >> 1;
    localparam logic [7:0] AW = {ADDR_SEL, `PSR_ADDR_LO, 1'b0};

    psr_host_st_t hst;
    logic [31:0] boot;
    logic [9:0] div;
    logic tick;
    logic mid;
    logic [3:0] bitn;
    logic [2:0] byten;
    logic [2:0] nbytes;
    logic spi;
    logic rd;
    logic [39:0] tx;
    logic [31:0] rx;
    logic scl_low;
    logic sda_low;
    logic sclk;
    logic mosi;
    logic ss_n;
    logic sda_m;
    logic sda_s;
    logic miso_m;
    logic miso_s;
    logic smp;
    logic ack_slot;
    logic last_bit;

    ////////////////////////////////////////////////////////////////////////
    // Start-up wait and line synchronisers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot <= 32'h0;
            ready_o <= 1'b0;
        end else if (boot >= BOOT_CYC) begin
            ready_o <= 1'b1;
        end else begin
            boot <= boot + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end else begin
            sda_m <= link.sda;
            sda_s <= sda_m;
            miso_m <= link.miso;
            miso_s <= miso_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: every state but h_idle lasts one half period of the serial clock

    assign tick = div == HALF - 10'h1;
    assign mid = div == MID;
    assign smp = spi ? miso_s : sda_s;
    assign ack_slot = !spi && bitn == 4'h8;
    assign last_bit = spi ? bitn == 4'h7 : bitn == 4'h8;

    always_ff @(posedge clk_i) begin
        if (rst_i || hst == h_idle || tick) begin
            div <= 10'h0;
        end else begin
            div <= div + 10'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hst <= h_idle;
            bitn <= 4'h0;
            byten <= 3'h0;
            nbytes <= 3'h0;
            spi <= 1'b0;
            rd <= 1'b0;
            tx <= 40'h0;
            rx <= 32'h0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            ss_n <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            ack_err_o <= 1'b0;
            status_o <= 8'h00;
            press_o <= 24'h0;
        end else begin
            done_o <= 1'b0;
            unique case (hst)
                h_idle: if (req_i && ready_o) begin
                    hst <= h_start;
                    busy_o <= 1'b1;
                    ack_err_o <= 1'b0;
                    spi <= spi_i;
                    rd <= read_i;
                    bitn <= 4'h0;
                    byten <= 3'h0;
                    if (spi_i) begin
                        ss_n <= 1'b0;
                        nbytes <= read_i ? 3'h4 : 3'h3;
                        tx <= read_i ? {`PSR_CMD_NOP, 32'hFF}
                                     : {`PSR_CMD_MEAS, `PSR_CMD_ARG, `PSR_CMD_ARG, 16'hFFFF};
                    end else begin
                        sda_low <= 1'b1;
                        nbytes <= read_i ? 3'h5 : 3'h4;
                        tx <= read_i ? {AW | 8'h01, 32'hFFFFFFFF}
                                     : {AW, `PSR_CMD_MEAS, `PSR_CMD_ARG, `PSR_CMD_ARG, 8'hFF};
                    end
                end
                h_start: if (tick) begin
                    hst <= h_blo;
                    scl_low <= !spi;
                end
                h_blo: begin
                    if (mid) begin
                        if (ack_slot) begin
                            // Acknowledge every read byte but the last
                            sda_low <= rd && byten != 3'h0 && byten != nbytes - 3'h1;
                        end else begin
                            sda_low <= !spi && !tx[39];
                            mosi <= tx[39];
                            tx <= {tx[38:0], 1'b1};
                        end
                    end
                    if (tick) begin
                        hst <= h_bhi;
                        scl_low <= 1'b0;
                        sclk <= spi;
                    end
                end
                h_bhi: if (tick) begin
                    if (ack_slot) begin
                        if ((!rd || byten == 3'h0) && smp) begin
                            ack_err_o <= 1'b1;
                        end
                    end else begin
                        rx <= {rx[30:0], smp};
                    end
                    scl_low <= !spi;
                    sclk <= 1'b0;
                    if (!last_bit) begin
                        bitn <= bitn + 4'h1;
                        hst <= h_blo;
                    end else begin
                        bitn <= 4'h0;
                        if (byten == nbytes - 3'h1) begin
                            hst <= h_stop;
                        end else begin
                            byten <= byten + 3'h1;
                            hst <= h_blo;
                        end
                    end
                end
                h_stop: begin
                    if (mid) begin
                        sda_low <= !spi;
                    end
                    if (tick) begin
                        hst <= h_stop2;
                        scl_low <= 1'b0;
                    end
                end
                h_stop2: if (tick) begin
                    hst <= h_done;
                    sda_low <= 1'b0;
                    ss_n <= 1'b1;
                end
                h_done: if (tick) begin
                    hst <= h_idle;
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    if (rd) begin
                        status_o <= rx[31:24];
                        press_o <= rx[23:0];
                    end
                end
                default: begin
                    hst <= h_idle;
                end
            endcase
        end
    end

    assign link.scl_h_o = 1'b0;
    assign link.scl_h_oe = scl_low;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe = sda_low;
    assign link.sclk = sclk;
    assign link.mosi = mosi;
    assign link.ss_n = ss_n;

endmodule // psr_master

// ### tb/psr_link_checker.sv
// Checker on the link wires between the master and the sensor.
// Assumes every watched line changes just after a core clock edge; miso_d flops on the falling sclk.
`timescale 1ns/1ps
module psr_link_checker (
    // Core domain
    input wire logic clk_i,
    input wire logic rst_i,
    // Four-wire bus
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic miso,
    input wire logic miso_d,
    input wire logic miso_oe,
    // Two-wire bus
    input wire logic scl,
    input wire logic sda_d_oe
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // Watches the sensor's own data flop; the resolved line is gated by construction
    a_miso_idle_low: assert property (ss_n |-> !miso_d)
        else $error("miso data high while deselected");
    a_miso_oe_sel: assert property (miso_oe == !ss_n)
        else $error("miso enable not tied to select");
    a_sclk_idle_low: assert property (ss_n |-> !sclk)
        else $error("sclk not low outside frame");
    a_mosi_low_phase: assert property ($changed(mosi) |-> !sclk)
        else $error("mosi moved while sclk high");
    a_miso_low_phase: assert property
        ($changed(miso) && !ss_n && !$past(ss_n) |-> !sclk)
        else $error("miso moved while sclk high");
    a_sel_lead_time: assert property ($fell(ss_n) |-> !sclk [*8])
        else $error("sclk too soon after select");
    a_first_bit_zero: assert property ($fell(ss_n) |-> !miso)
        else $error("first status bit not zero");
    a_sda_low_phase: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("sensor moved sda while scl high");
    a_sda_ack_hold: assert property ($rose(sda_d_oe) |-> !scl [*4])
        else $error("sensor drive not in low phase");
endmodule // psr_link_checker

// ### tb/tb_pressure_sensor_serial_readout.sv
// Bench: master and sensor joined over the link, command then readout.
// Assumes shortened start-up counts; serial clocks come from the master.
`timescale 1ns/1ps
`include "psr_consts.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_pressure_sensor_serial_readout;
    logic clk_i = 0, rst_i = 1, req_i = 0, spi_i = 0, read_i = 0;
    logic sat_i, mem_fault_i, s_busy, ready_o, busy_o, done_o, ack_err_o;
    logic [23:0] press_i, press_o;
    logic [7:0] status_o;
    logic [31:0] mi = 32'h0, mo = 32'h0;
    logic [7:0] exp_q[$];
    int error_cnt = 0, n_tests = 0, cyc = 0, n, seed = 48989;
    always #2.5 clk_i = ~clk_i;
    psr_link_if lk ();
    psr_sensor #(.CMD_CYC(200), .MEAS_CYC(400)) u_psr_sensor (.clk_i(clk_i), .rst_i(rst_i),
        .press_i(press_i), .sat_i(sat_i), .mem_fault_i(mem_fault_i), .busy_o(s_busy), .link(lk));
    psr_master #(.BOOT_CYC(200)) u_psr_master (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
        .spi_i(spi_i), .read_i(read_i), .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o),
        .ack_err_o(ack_err_o), .status_o(status_o), .press_o(press_o), .link(lk));
    psr_link_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .sclk(lk.sclk), .mosi(lk.mosi),
        .ss_n(lk.ss_n), .miso(lk.miso), .miso_d(lk.miso_d), .miso_oe(lk.miso_oe), .scl(lk.scl),
        .sda_d_oe(lk.sda_d_oe));
    ////////////////////////////////////////////////////////////////
    // Wire monitor: what each end samples on each rising sclk
    always @(posedge lk.sclk) if (!lk.ss_n) begin
        mi <= {mi[30:0], lk.miso};
        mo <= {mo[30:0], lk.mosi};
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // A hung transfer would otherwise stall the run; the four frames take about 74000 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task xfer(input logic s, input logic r);
        // Keeps the bus free long enough between frames on either bus
        repeat (200) @(posedge clk_i);
        req_i <= 1'b1;
        spi_i <= s;
        read_i <= r;
        @(posedge clk_i);
        req_i <= 1'b0;
        do @(negedge clk_i); while (done_o !== 1'b1);
        `CHK("host busy", 1'b0, busy_o)
    endtask
    // Sensor busy rises inside the command frame, so it is watched alongside it
    task watch_conv;
        n = 0;
        while (s_busy !== 1'b1 && n < 30000) begin @(negedge clk_i); n++; end
        `CHK("busy set", 1'b1, s_busy)
        n = 0;
        while (s_busy === 1'b1 && n < 2000) begin @(negedge clk_i); n++; end
        `CHK("standby", `PSR_CONV_CYC, n)
    endtask
    // Reference model: status from the rules, then the pressure bytes in order
    task check_result;
        logic [23:0] pw;
        exp_q = {};
        exp_q.push_back({1'b0, 1'b1, 1'b0, 2'b00, mem_fault_i, 1'b0, sat_i});
        for (int k = 2; k >= 0; k--) exp_q.push_back(press_i[8 * k +: 8]);
        pw = {exp_q[1], exp_q[2], exp_q[3]};
        `CHK("status", exp_q[0], status_o)
        `CHK("press", pw, press_o)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        press_i <= 24'($random(seed));
        sat_i <= 1'($random(seed));
        mem_fault_i <= 1'($random(seed));
        do @(negedge clk_i); while (ready_o !== 1'b1);
        fork
            xfer(1'b0, 1'b0);
            watch_conv();
        join
        `CHK("addr ack", 1'b0, ack_err_o)
        $display("test two-wire command done");
        xfer(1'b0, 1'b1);
        check_result();
        `CHK("read ack", 1'b0, ack_err_o)
        $display("test two-wire readout done");
        @(posedge clk_i);
        press_i <= 24'($random(seed));
        sat_i <= 1'($random(seed));
        fork
            xfer(1'b1, 1'b0);
            watch_conv();
        join
        `CHK("cmd bytes", 24'hAA0000, mo[23:0])
        $display("test four-wire command done");
        xfer(1'b1, 1'b1);
        check_result();
        for (int k = 0; k < 4; k++) `CHK("miso byte", exp_q[k], mi[31 - 8 * k -: 8])
        `CHK("nop byte", 8'hF0, mo[31:24])
        $display("test four-wire readout done");
        print_verdict();
    end
endmodule // tb_pressure_sensor_serial_readout
